// ===== design/tavg_regs.v
// transducer register bank with averaging engine
`timescale 1ns/100ps
`include "tavg_map.vh"

// How it works
// - status indicator red during initialisation, green afterwards
// - each accepted configuration write gives a short red flash
// - before window fills, mean of collected samples only
// - full window slides, newest sample replaces oldest
// - out-of-range sample flagged and valid count restarts
// - averaging code 0 to 12 selects thirteen averaging times
// - up to 30 s, half-second samples, window 1 to 60
// - 1 min and longer, 100 samples at longer intervals
// - averaging time defaults to one second
// - overflow handling substitutes lower or upper output values
// - output source code selects normal, lower or upper value
// - overflow register 0 disables, 1 enables substitution
// - station address accepts 1 to 247
// - framing code selects four character formats
// - baud code selects 4800, 9600 or 19200
// - framing and baud take effect only on apply write
// - status bit 15 shows uncalibrated input
// - status bits 14, 13, 12: parameter error, overflow, averaging
// - status bits 6..3 input type, 2..0 output type RS-485
module tavg_regs #(
    parameter DW = 16,
    parameter [3:0] INPUT_TYPE = 4'h1,
    parameter [15:0] FW_REV = 16'h0100, // arbitrary value
    parameter TICK_CYC = `TAVG_CLK_HZ / 1000 * `TAVG_TICK_MS,
    parameter FLASH_CYC = `TAVG_CLK_HZ / 1000 * `TAVG_FLASH_MS,
    parameter INIT_CYC = `TAVG_CLK_HZ / 1000 * `TAVG_INIT_MS
) (
    // clock and reset
    input wire MCLK,
    input wire RST,
    // register port from the protocol engine
    input wire REG_WR,
    input wire REG_RD,
    input wire [15:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    output reg [15:0] REG_RDATA,
    output reg REG_ACK,
    // measurement path
    input wire SMP_VALID,
    input wire signed [DW-1:0] SMP_DATA,
    input wire SMP_OUT_RANGE,
    output reg SMP_REQ,
    // limits and substitution values
    input wire signed [DW-1:0] IN_LOW,
    input wire signed [DW-1:0] IN_HIGH,
    input wire signed [DW-1:0] OUT_LOW,
    input wire signed [DW-1:0] OUT_HIGH,
    output reg signed [DW-1:0] OUT_VALUE,
    // device condition pins
    input wire UNCAL,
    input wire PARAM_ERR,
    // serial link settings in force
    output reg [7:0] LINK_ADDR,
    output reg [1:0] LINK_FRAMING,
    output reg [1:0] LINK_BAUD,
    // status indicator
    output reg LED_RED,
    output reg LED_GREEN
);

    reg uncal_s1;
    reg uncal_reg;
    reg perr_s1;
    reg perr_reg;
    reg [3:0] avg_reg;
    reg [1:0] cos_reg;
    reg ovf_reg;
    reg [1:0] frm_reg;
    reg [1:0] baud_reg;
    reg range_reg;
    reg [31:0] init_cnt_reg;
    reg init_done_reg;
    reg [31:0] flash_cnt_reg;
    reg [31:0] tick_cnt_reg;
    reg [9:0] tick_div_reg;
    reg [9:0] ivl_len;
    reg [6:0] win_len;
    reg [15:0] rd_next;
    reg [15:0] status_word;
    reg led_red_next;
    reg led_green_next;
    reg wr_ok;

    wire win_clear;
    wire signed [DW-1:0] mean;
    wire mean_valid;
    wire win_full;
    wire tick = (tick_cnt_reg == TICK_CYC - 1);

    // window length in samples and sample interval in 10 ms ticks
    always @* begin
        case (avg_reg)
            4'h0: begin
                win_len = `TAVG_WIN_HALF_S;
                ivl_len = `TAVG_IVL_HALF_S;
            end
            4'h1: begin
                win_len = `TAVG_WIN_1S;
                ivl_len = `TAVG_IVL_HALF_S;
            end
            4'h2: begin
                win_len = `TAVG_WIN_3S;
                ivl_len = `TAVG_IVL_HALF_S;
            end
            4'h3: begin
                win_len = `TAVG_WIN_5S;
                ivl_len = `TAVG_IVL_HALF_S;
            end
            4'h4: begin
                win_len = `TAVG_WIN_10S;
                ivl_len = `TAVG_IVL_HALF_S;
            end
            4'h5: begin
                win_len = `TAVG_WIN_15S;
                ivl_len = `TAVG_IVL_HALF_S;
            end
            4'h6: begin
                win_len = `TAVG_WIN_30S;
                ivl_len = `TAVG_IVL_HALF_S;
            end
            4'h7: begin
                win_len = `TAVG_WIN_FULL;
                ivl_len = `TAVG_IVL_1M;
            end
            4'h8: begin
                win_len = `TAVG_WIN_FULL;
                ivl_len = `TAVG_IVL_2M;
            end
            4'h9: begin
                win_len = `TAVG_WIN_FULL;
                ivl_len = `TAVG_IVL_5M;
            end
            4'ha: begin
                win_len = `TAVG_WIN_FULL;
                ivl_len = `TAVG_IVL_7M;
            end
            4'hb: begin
                win_len = `TAVG_WIN_FULL;
                ivl_len = `TAVG_IVL_12M;
            end
            4'hc: begin
                win_len = `TAVG_WIN_FULL;
                ivl_len = `TAVG_IVL_15M;
            end
            default: begin
                win_len = `TAVG_WIN_FULL;
                ivl_len = `TAVG_IVL_15M;
            end
        endcase
    end

    // write range checks
    always @* begin
        case (REG_ADDR)
            `TAVG_ADDR_AVG: wr_ok = (REG_WDATA <= `TAVG_AVG_MAX);
            `TAVG_ADDR_COS: wr_ok = (REG_WDATA <= `TAVG_COS_MAX);
            `TAVG_ADDR_OVF: wr_ok = (REG_WDATA <= `TAVG_OVF_MAX);
            `TAVG_ADDR_STA: wr_ok = (REG_WDATA >= `TAVG_STA_MIN) &&
                                    (REG_WDATA <= `TAVG_STA_MAX);
            `TAVG_ADDR_FRM: wr_ok = (REG_WDATA <= `TAVG_FRM_MAX);
            `TAVG_ADDR_BAUD: wr_ok = (REG_WDATA <= `TAVG_BAUD_MAX);
            `TAVG_ADDR_APPLY: wr_ok = (REG_WDATA <= `TAVG_APPLY_GO);
            default: wr_ok = 1'b0;
        endcase
    end
    wire wr_acc = REG_WR && wr_ok && init_done_reg;

    // status word
    always @* begin
        status_word = 16'h0000;
        status_word[`TAVG_ST_UNCAL] = uncal_reg;
        status_word[`TAVG_ST_PARERR] = perr_reg;
        status_word[`TAVG_ST_RANGE] = range_reg;
        status_word[`TAVG_ST_AVGRUN] = ~win_full;
        status_word[`TAVG_ST_IN_LSB+3:`TAVG_ST_IN_LSB] = INPUT_TYPE;
        status_word[2:0] = `TAVG_OUT_RS485;
    end

    // read mux
    always @* begin
        case (REG_ADDR)
            `TAVG_ADDR_AVG: rd_next = {12'h000, avg_reg};
            `TAVG_ADDR_COS: rd_next = {14'h0000, cos_reg};
            `TAVG_ADDR_OVF: rd_next = {15'h0000, ovf_reg};
            `TAVG_ADDR_STA: rd_next = {8'h00, LINK_ADDR};
            `TAVG_ADDR_FRM: rd_next = {14'h0000, frm_reg};
            `TAVG_ADDR_BAUD: rd_next = {14'h0000, baud_reg};
            `TAVG_ADDR_STAT: rd_next = status_word;
            `TAVG_ADDR_FW: rd_next = FW_REV;
            default: rd_next = 16'h0000;
        endcase
    end

    // register bank
    always @(posedge MCLK) begin
        if (RST) begin
            avg_reg <= `TAVG_AVG_RST;
            cos_reg <= `TAVG_COS_NORMAL;
            ovf_reg <= 1'b0;
            LINK_ADDR <= `TAVG_STA_RST;
            frm_reg <= `TAVG_FRM_RST;
            baud_reg <= `TAVG_BAUD_RST;
            LINK_FRAMING <= `TAVG_FRM_RST;
            LINK_BAUD <= `TAVG_BAUD_RST;
            REG_RDATA <= 16'h0000;
            REG_ACK <= 1'b0;
        end else begin
            REG_ACK <= REG_RD || wr_acc;
            if (REG_RD)
                REG_RDATA <= rd_next;
            if (wr_acc) begin
                case (REG_ADDR)
                    `TAVG_ADDR_AVG: avg_reg <= REG_WDATA[3:0];
                    `TAVG_ADDR_COS: cos_reg <= REG_WDATA[1:0];
                    `TAVG_ADDR_OVF: ovf_reg <= REG_WDATA[0];
                    `TAVG_ADDR_STA: LINK_ADDR <= REG_WDATA[7:0];
                    `TAVG_ADDR_FRM: frm_reg <= REG_WDATA[1:0];
                    `TAVG_ADDR_BAUD: baud_reg <= REG_WDATA[1:0];
                    `TAVG_ADDR_APPLY: begin
                        if (REG_WDATA[0]) begin
                            LINK_FRAMING <= frm_reg;
                            LINK_BAUD <= baud_reg;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // condition pin synchronisers
    always @(posedge MCLK) begin
        if (RST) begin
            uncal_s1 <= 1'b0;
            uncal_reg <= 1'b0;
            perr_s1 <= 1'b0;
            perr_reg <= 1'b0;
        end else begin
            uncal_s1 <= UNCAL;
            uncal_reg <= uncal_s1;
            perr_s1 <= PARAM_ERR;
            perr_reg <= perr_s1;
        end
    end

    // sample pacing in 10 ms ticks
    always @(posedge MCLK) begin
        if (RST) begin
            tick_cnt_reg <= 32'h0;
            tick_div_reg <= 10'h000;
            SMP_REQ <= 1'b0;
        end else begin
            SMP_REQ <= 1'b0;
            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
            if (tick) begin
                if (tick_div_reg >= ivl_len - 10'h001) begin
                    tick_div_reg <= 10'h000;
                    SMP_REQ <= init_done_reg;
                end else begin
                    tick_div_reg <= tick_div_reg + 10'h001;
                end
            end
        end
    end

    // out of range flag
    always @(posedge MCLK) begin
        if (RST)
            range_reg <= 1'b0;
        else if (SMP_VALID)
            range_reg <= SMP_OUT_RANGE;
    end

    assign win_clear = (SMP_VALID && SMP_OUT_RANGE) ||
                       (wr_acc && REG_ADDR == `TAVG_ADDR_AVG);

    tavg_window #(.DW(DW), .DEPTH(`TAVG_WIN_FULL), .AW(7)) u_window (
        .clk(MCLK),
        .rst(RST),
        .clear(win_clear),
        .win_len(win_len),
        .smp_valid(SMP_VALID && !SMP_OUT_RANGE),
        .smp(SMP_DATA),
        .mean(mean),
        .mean_valid(mean_valid),
        .full(win_full)
    );

    // output value selection
    always @(posedge MCLK) begin
        if (RST)
            OUT_VALUE <= {DW{1'b0}};
        else if (cos_reg == `TAVG_COS_LOWER)
            OUT_VALUE <= OUT_LOW;
        else if (cos_reg == `TAVG_COS_UPPER)
            OUT_VALUE <= OUT_HIGH;
        else if (ovf_reg && mean <= IN_LOW)
            OUT_VALUE <= OUT_LOW;
        else if (ovf_reg && mean >= IN_HIGH)
            OUT_VALUE <= OUT_HIGH;
        else
            OUT_VALUE <= mean;
    end

    // status indicator colours
    always @* begin
        led_red_next = !init_done_reg || wr_acc ||
                       (flash_cnt_reg > 32'h1);
        led_green_next = init_done_reg && !wr_acc &&
                         (flash_cnt_reg <= 32'h1);
    end

    // status indicator
    always @(posedge MCLK) begin
        if (RST) begin
            init_cnt_reg <= 32'h0;
            init_done_reg <= 1'b0;
            flash_cnt_reg <= 32'h0;
            LED_RED <= 1'b1;
            LED_GREEN <= 1'b0;
        end else begin
            if (!init_done_reg) begin
                init_cnt_reg <= init_cnt_reg + 32'h1;
                if (init_cnt_reg == INIT_CYC - 1)
                    init_done_reg <= 1'b1;
            end
            if (wr_acc)
                flash_cnt_reg <= FLASH_CYC;
            else if (flash_cnt_reg != 32'h0)
                flash_cnt_reg <= flash_cnt_reg - 32'h1;
            LED_RED <= led_red_next;
            LED_GREEN <= led_green_next;
        end
    end

endmodule // tavg_regs

// ===== design/tavg_map.vh
// register offsets, codes, field positions and timing constants
`ifndef TAVG_MAP_VH
`define TAVG_MAP_VH
`define TAVG_ADDR_AVG 16'h0fa0
`define TAVG_ADDR_COS 16'h0fa1
`define TAVG_ADDR_OVF 16'h0fa2
`define TAVG_ADDR_STA 16'h0fa3
`define TAVG_ADDR_FRM 16'h0fa4
`define TAVG_ADDR_BAUD 16'h0fa5
`define TAVG_ADDR_APPLY 16'h0fa6
`define TAVG_ADDR_STAT 16'h0fa7
`define TAVG_ADDR_RSA 16'h0fa8
`define TAVG_ADDR_RSB 16'h0fa9
`define TAVG_ADDR_RSC 16'h0faa
`define TAVG_ADDR_FW 16'h0fab
`define TAVG_AVG_MAX 16'h000c
`define TAVG_AVG_RST 4'h1
`define TAVG_COS_MAX 16'h0002
`define TAVG_COS_NORMAL 2'h0
`define TAVG_COS_LOWER 2'h1
`define TAVG_COS_UPPER 2'h2
`define TAVG_OVF_MAX 16'h0001
`define TAVG_STA_MIN 16'h0001
`define TAVG_STA_MAX 16'h00f7
`define TAVG_STA_RST 8'h01
`define TAVG_FRM_MAX 16'h0003
`define TAVG_FRM_RST 2'h3
`define TAVG_BAUD_MAX 16'h0002
`define TAVG_BAUD_RST 2'h1
`define TAVG_APPLY_GO 16'h0001
`define TAVG_ST_UNCAL 15
`define TAVG_ST_PARERR 14
`define TAVG_ST_RANGE 13
`define TAVG_ST_AVGRUN 12
`define TAVG_ST_IN_LSB 3
`define TAVG_OUT_RS485 3'h4
`define TAVG_CLK_HZ 20000000
`define TAVG_HALF_SEC_MS 500
`define TAVG_TICK_MS 10
`define TAVG_FLASH_MS 100
`define TAVG_INIT_MS 500
`define TAVG_WIN_FULL 7'd100
`define TAVG_WIN_HALF_S 7'h01
`define TAVG_WIN_1S 7'h02
`define TAVG_WIN_3S 7'h06
`define TAVG_WIN_5S 7'h0a
`define TAVG_WIN_10S 7'h14
`define TAVG_WIN_15S 7'h1e
`define TAVG_WIN_30S 7'h3c
`define TAVG_IVL_HALF_S 10'h032
`define TAVG_IVL_1M 10'h03c
`define TAVG_IVL_2M 10'h079
`define TAVG_IVL_5M 10'h12c
`define TAVG_IVL_7M 10'h1a4
`define TAVG_IVL_12M 10'h258
`define TAVG_IVL_15M 10'h38e
`endif

// ===== design/tavg_window.v
// sliding window mean of signed samples
`timescale 1ns/100ps
module tavg_window #(
    parameter DW = 16,
    parameter DEPTH = 100,
    parameter AW = 7
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire clear,
    input wire [AW-1:0] win_len,
    // sample in
    input wire smp_valid,
    input wire signed [DW-1:0] smp,
    // result
    output reg signed [DW-1:0] mean,
    output reg mean_valid,
    output reg full
);
    localparam SW = DW + AW + 1;
    reg signed [DW-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] cnt_reg;
    reg signed [SW-1:0] sum_reg;
    reg [AW-1:0] div_den;
    reg div_busy;
    reg [SW-1:0] quo;
    reg [SW-1:0] rem;
    reg [5:0] step;
    reg neg;
    wire [AW-1:0] cnt_inc = cnt_reg + 1'b1;
    wire at_full = (cnt_reg == win_len);
    wire [AW-1:0] old_idx = (wr_reg >= win_len) ? wr_reg - win_len
                            : wr_reg + DEPTH[AW-1:0] - win_len;
    wire signed [SW-1:0] smp_ext = {{(SW-DW){smp[DW-1]}}, smp};
    wire signed [SW-1:0] old_ext = {{(SW-DW){mem[old_idx][DW-1]}},
                                     mem[old_idx]};
    wire signed [SW-1:0] sum_next = at_full ? sum_reg + smp_ext - old_ext
                                    : sum_reg + smp_ext;
    wire [SW-1:0] rem_sh = {rem[SW-2:0], quo[SW-1]};
    always @(posedge clk) begin
        if (rst || clear) begin
            wr_reg <= {AW{1'b0}};
            cnt_reg <= {AW{1'b0}};
            sum_reg <= {SW{1'b0}};
            full <= 1'b0;
            div_busy <= 1'b0;
            mean_valid <= 1'b0;
        end else begin
            mean_valid <= 1'b0;
            if (smp_valid) begin
                mem[wr_reg] <= smp;
                wr_reg <= (wr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_reg + 1'b1;
                sum_reg <= sum_next;
                if (!at_full)
                    cnt_reg <= cnt_inc;
                full <= at_full || (cnt_inc == win_len);
                div_den <= at_full ? win_len : cnt_inc;
                neg <= sum_next[SW-1];
                quo <= sum_next[SW-1] ? -sum_next : sum_next;
                rem <= {SW{1'b0}};
                step <= SW[5:0];
                div_busy <= 1'b1;
            end else if (div_busy) begin
                if (rem_sh >= {{(SW-AW){1'b0}}, div_den}) begin
                    rem <= rem_sh - {{(SW-AW){1'b0}}, div_den};
                    quo <= {quo[SW-2:0], 1'b1};
                end else begin
                    rem <= rem_sh;
                    quo <= {quo[SW-2:0], 1'b0};
                end
                step <= step - 1'b1;
                if (step == 6'h01) begin
                    div_busy <= 1'b0;
                end
            end else if (step == 6'h00 && !mean_valid && quo != 0) begin
                step <= 6'h3f;
            end
            if (div_busy && step == 6'h01) begin
                mean_valid <= 1'b1;
            end
        end
    end
    always @(posedge clk) begin
        if (rst)
            mean <= {DW{1'b0}};
        else if (mean_valid)
            mean <= neg ? -quo[DW-1:0] : quo[DW-1:0];
    end
endmodule // tavg_window

// ===== dv/tavg_chk_assertions.sv
// concurrent checks on the register bank ports
`timescale 1ns/100ps
`include "tavg_map.vh"
module tavg_chk #(
    parameter DW = 16
) (
    // clock and reset
    input wire MCLK,
    input wire RST,
    // register port
    input wire REG_WR,
    input wire REG_RD,
    input wire [15:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire [15:0] REG_RDATA,
    input wire REG_ACK,
    // output path
    input wire signed [DW-1:0] OUT_LOW,
    input wire signed [DW-1:0] OUT_VALUE,
    // status and link
    input wire UNCAL,
    input wire [1:0] LINK_FRAMING,
    input wire [1:0] LINK_BAUD,
    input wire LED_RED,
    input wire LED_GREEN
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_red;
        LED_RED && !LED_GREEN;
    endsequence
    sequence s_calm;
        $stable(UNCAL) [*4];
    endsequence
    property p_rd_ack;
        REG_RD |=> REG_ACK;
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read not acked");
    property p_ro;
        REG_WR && REG_ADDR >= `TAVG_ADDR_STAT |=> !REG_ACK;
    endproperty
    a_ro: assert property (p_ro) else $error("read-only write acked");
    property p_avg_rng;
        REG_WR && REG_ADDR == `TAVG_ADDR_AVG && REG_WDATA > `TAVG_AVG_MAX
            |=> !REG_ACK;
    endproperty
    a_avg_rng: assert property (p_avg_rng) else $error("bad code acked");
    property p_flash;
        REG_ACK && $past(REG_WR) |-> s_red ##1 s_red;
    endproperty
    a_flash: assert property (p_flash) else $error("no red flash");
    property p_init;
        $fell(RST) |-> s_red [*8];
    endproperty
    a_init: assert property (p_init) else $error("not red at start");
    property p_force;
        REG_WR && REG_ADDR == `TAVG_ADDR_COS && REG_WDATA == 16'h0001
            ##1 REG_ACK |=> OUT_VALUE == OUT_LOW;
    endproperty
    a_force: assert property (p_force) else $error("lower not forced");
    property p_link;
        $changed({LINK_FRAMING, LINK_BAUD}) |->
            $past(REG_WR && REG_ADDR == `TAVG_ADDR_APPLY) ||
            $past(REG_WR && REG_ADDR == `TAVG_ADDR_APPLY, 2);
    endproperty
    a_link: assert property (p_link) else $error("link changed early");
    property p_uncal;
        s_calm ##0 (REG_RD && REG_ADDR == `TAVG_ADDR_STAT)
            |=> REG_RDATA[15] == $past(UNCAL);
    endproperty
    a_uncal: assert property (p_uncal) else $error("bit 15 wrong");
endmodule // tavg_chk
bind tavg_regs tavg_chk #(.DW(DW)) u_chk (.MCLK(MCLK), .RST(RST),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
    .OUT_LOW(OUT_LOW), .OUT_VALUE(OUT_VALUE), .UNCAL(UNCAL),
    .LINK_FRAMING(LINK_FRAMING), .LINK_BAUD(LINK_BAUD),
    .LED_RED(LED_RED), .LED_GREEN(LED_GREEN));

// ===== dv/tavg_src.sv
// measurement source answering sample requests
`timescale 1ns/100ps
module tavg_src (
    // clock and reset
    input wire clk,
    input wire rst,
    // handshake
    input wire req,
    output reg vld,
    // sample
    input wire signed [15:0] nxt,
    input wire nxt_oor,
    output reg signed [15:0] smp,
    output reg oor
);
    reg [1:0] dly_reg;
    always @(posedge clk) begin
        if (rst) begin
            dly_reg <= 2'h0;
            vld <= 1'b0;
            smp <= 16'h0000;
            oor <= 1'b0;
        end else begin
            dly_reg <= {dly_reg[0], req};
            vld <= dly_reg[1];
            smp <= dly_reg[1] ? nxt : ~smp;
            oor <= dly_reg[1] & nxt_oor;
        end
    end
endmodule // tavg_src

// ===== dv/tavg_regs_tb.sv
// self-checking bench for the register bank
`timescale 1ns/100ps
`include "tavg_map.vh"
module tavg_regs_tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [15:0] adr = 16'h0000;
    reg [15:0] wd = 16'h0000;
    reg uncal = 1'b0;
    reg signed [15:0] nxt = 16'h0000;
    reg nxt_oor = 1'b0;
    reg perr = 1'b0;
    reg signed [15:0] olo = 16'h0111;
    reg signed [15:0] ohi = 16'h0777;
    wire [15:0] rdata;
    wire signed [15:0] smp, outv;
    wire ack, req, vld, oor, red, green;
    wire [7:0] ladr;
    wire [1:0] lfrm, lbaud;
    reg [15:0] v;
    reg [3:0] lk;
    integer err_total = 0;
    integer n_checks = 0;
    integer i;
    always #25 clk = ~clk;
    tavg_regs #(.TICK_CYC(1), .FLASH_CYC(5), .INIT_CYC(20)) u_dut (
        .MCLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(adr),
        .REG_WDATA(wd), .REG_RDATA(rdata), .REG_ACK(ack),
        .SMP_VALID(vld), .SMP_DATA(smp), .SMP_OUT_RANGE(oor), .SMP_REQ(req),
        .IN_LOW(16'hfc18), .IN_HIGH(16'h03e8), .OUT_LOW(olo),
        .OUT_HIGH(ohi), .OUT_VALUE(outv), .UNCAL(uncal),
        .PARAM_ERR(perr), .LINK_ADDR(ladr), .LINK_FRAMING(lfrm),
        .LINK_BAUD(lbaud), .LED_RED(red), .LED_GREEN(green));
    tavg_src u_src (.clk(clk), .rst(rst), .req(req), .vld(vld),
        .nxt(nxt), .nxt_oor(nxt_oor), .smp(smp), .oor(oor));
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
            end
        end
    endtask
    task wr_reg(input [15:0] a, input [15:0] d, input ok);
        begin
            @(posedge clk);
            wr <= 1'b1;
            adr <= a;
            wd <= d;
            @(posedge clk);
            wr <= 1'b0;
            #1 chk({15'h0, ack}, {15'h0, ok});
        end
    endtask
    task rd_reg(input [15:0] a, output [15:0] d);
        begin
            @(posedge clk);
            rd <= 1'b1;
            adr <= a;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk({15'h0, ack}, 16'h0001);
            d = rdata;
        end
    endtask
    task wr_rb(input [15:0] a, input [15:0] d, input ok, input [15:0] e);
        begin
            wr_reg(a, d, ok);
            rd_reg(a, v);
            chk(v, e);
        end
    endtask
    task take(input [15:0] s, input o);
        integer j;
        begin
            @(posedge clk);
            nxt <= s;
            nxt_oor <= o;
            #1;
            for (j = 0; j < 200 && vld !== 1'b1; j = j + 1) begin
                @(posedge clk);
                #1;
            end
            chk({15'h0, vld}, 16'h0001);
            repeat (30) @(posedge clk);
            #1;
        end
    endtask
    task close_out;
        begin
            if (err_total == 0 && n_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total = err_total + 1;
        close_out;
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 chk({14'h0, red, green}, 16'h0002);
        @(posedge clk);
        rst <= 1'b0;
        wr_rb(`TAVG_ADDR_AVG, 16'h0005, 1'b0, `TAVG_AVG_RST);
        repeat (30) @(posedge clk);
        #1 chk({14'h0, red, green}, 16'h0001);
        wr_rb(`TAVG_ADDR_AVG, 16'h000c, 1'b1, 16'h000c);
        #1 chk({15'h0, red}, 16'h0001);
        wr_rb(`TAVG_ADDR_AVG, 16'h000d, 1'b0, 16'h000c);
        wr_rb(`TAVG_ADDR_COS, 16'h0003, 1'b0, 16'h0000);
        wr_rb(`TAVG_ADDR_OVF, 16'h0002, 1'b0, 16'h0000);
        wr_rb(`TAVG_ADDR_STA, 16'h0000, 1'b0, 16'h0001);
        wr_rb(`TAVG_ADDR_STA, 16'h00f8, 1'b0, 16'h0001);
        wr_rb(`TAVG_ADDR_STA, 16'h00f7, 1'b1, 16'h00f7);
        chk({8'h0, ladr}, 16'h00f7);
        wr_rb(`TAVG_ADDR_FRM, 16'h0004, 1'b0, 16'h0003);
        wr_rb(`TAVG_ADDR_BAUD, 16'h0003, 1'b0, 16'h0001);
        for (i = 0; i < 5; i = i + 1)
            wr_reg(16'h0fa7 + i[15:0], 16'hffff, 1'b0);
        wr_rb(`TAVG_ADDR_RSA, 16'h0001, 1'b0, 16'h0000);
        wr_rb(16'h0fb0, 16'h0001, 1'b0, 16'h0000);
        repeat (8) @(posedge clk);
        #1 chk({14'h0, red, green}, 16'h0001);
        lk = 4'hd;
        for (i = 0; i < 4; i = i + 1) begin
            wr_reg(`TAVG_ADDR_FRM, i[15:0], 1'b1);
            wr_reg(`TAVG_ADDR_BAUD, i == 2 ? 16'h2 : {15'h0, i[0]}, 1'b1);
            chk({12'h0, lfrm, lbaud}, {12'h0, lk});
            wr_reg(`TAVG_ADDR_APPLY, `TAVG_APPLY_GO, 1'b1);
            lk = {i[1:0], i == 2 ? 2'h2 : {1'b0, i[0]}};
            repeat (2) @(posedge clk);
            #1 chk({12'h0, lfrm, lbaud}, {12'h0, lk});
        end
        uncal <= 1'b1;
        perr <= 1'b1;
        wr_reg(`TAVG_ADDR_AVG, 16'h0001, 1'b1);
        take(16'h0064, 1'b0);
        chk(outv, 16'h0064);
        take(16'h00c8, 1'b0);
        chk(outv, 16'h0096);
        take(16'h0190, 1'b0);
        chk(outv, 16'h012c);
        take(16'h0190, 1'b1);
        rd_reg(`TAVG_ADDR_STAT, v);
        chk(v & 16'hf07f, 16'hf00c);
        take(16'h0258, 1'b0);
        chk(outv, 16'h0258);
        wr_reg(`TAVG_ADDR_OVF, 16'h0001, 1'b1);
        take(16'h07d0, 1'b0);
        chk(outv, 16'h0777);
        take(16'hf830, 1'b0);
        take(16'hf830, 1'b0);
        chk(outv, 16'h0111);
        wr_reg(`TAVG_ADDR_OVF, 16'h0000, 1'b1);
        take(16'hf830, 1'b0);
        chk(outv, 16'hf830);
        uncal <= 1'b0;
        perr <= 1'b0;
        wr_reg(`TAVG_ADDR_COS, 16'h0002, 1'b1);
        @(posedge clk);
        #1 chk(outv, 16'h0777);
        wr_reg(`TAVG_ADDR_COS, 16'h0001, 1'b1);
        @(posedge clk);
        #1 chk(outv, 16'h0111);
        rd_reg(`TAVG_ADDR_STAT, v);
        chk(v & 16'hc000, 16'h0000);
        close_out;
    end
endmodule // tavg_regs_tb
